// ===== src/acls_core.sv
// Accumulator, stack, loads, stores, pop, AND and status flags
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Double-word load fills all 32 accumulator bits from two words or immediate
// - Double-word load accepts an eight-hex-digit immediate
// - Back-to-back loads push the first value onto the stack
// - Bit-field load copies 1 to 32 discrete bits into accumulator
// - Bit-field load zeroes accumulator bits above the count
// - Octal address load converts octal digits to binary
// - Word store writes accumulator low 16 bits
// - Double-word store writes 32 bits to two consecutive words
// - Bit-field store writes 1 to 32 accumulator bits to discrete memory
// - Pop moves top stack entry to accumulator, shifts stack up
// - Pop sets zero flag when the popped value is zero
// - Word AND combines low 16 bits with a memory word
// - AND updates zero flag from the result
// - Double-word AND combines 32 bits with two words or immediate
// - Double-word AND sets negative flag from result bit 31
// - Flags hold until the next operation updating them
// - Pointer operands of loads and stores out of word memory raise pointer range flag
// - Every load sets load-zero flag when the loaded value is zero
// - Stack holds eight entries; push when full drops the deepest
// - Accumulator clears at end of scan
// - Word load clears upper 16 bits
// - A store cancels the pending push
module acls_core
   import acls_pkg::*;
#(
   parameter int DEPTH = ACLS_DEPTH
)
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   // Sequencer
   input  wire acls_pkg::acls_op_e    op,
   input  wire logic                  op_valid,
   input  wire acls_pkg::acls_src_e   op_src,
   input  wire logic [acls_pkg::ACLS_AW-1:0]   op_addr,
   input  wire logic [acls_pkg::ACLS_DW-1:0]   op_imm,
   input  wire logic [acls_pkg::ACLS_CNTW-1:0] op_count,
   input  wire logic                  scan_end,
   output logic                       op_done,
   // Word memory
   output logic                       wmem_rd,
   output logic                       wmem_wr,
   output logic [acls_pkg::ACLS_AW-1:0]        wmem_addr,
   output logic [acls_pkg::ACLS_WW-1:0]        wmem_wdata,
   input  wire logic [acls_pkg::ACLS_WW-1:0]   wmem_rdata,
   // Discrete bit memory
   output logic                       bmem_rd,
   output logic                       bmem_wr,
   output logic [acls_pkg::ACLS_BAW-1:0]       bmem_addr,
   output logic                       bmem_wdata,
   input  wire logic                  bmem_rdata,
   // State and flags
   output logic [acls_pkg::ACLS_DW-1:0]        acc,
   output logic                       result_zero_flag,
   output logic                       result_negative_flag,
   output logic                       load_zero_flag,
   output logic                       pointer_range_error_flag
);
   import acls_pkg::*;

   typedef enum logic [2:0]
   {
      ACLS_S_IDLE  = 3'b000,
      ACLS_S_PTR   = 3'b001,
      ACLS_S_WRD0  = 3'b011,
      ACLS_S_WRD1  = 3'b010,
      ACLS_S_BIT   = 3'b110,
      ACLS_S_FIN   = 3'b111
   } acls_state_e;

   acls_state_e              state_r;
   acls_op_e                 op_r;
   acls_src_e                src_r;
   logic [ACLS_AW-1:0]       addr_r;
   logic [ACLS_DW-1:0]       opnd_r;
   logic [ACLS_CNTW-1:0]     cnt_r;
   logic [ACLS_CNTW-1:0]     idx_r;
   logic [ACLS_DW-1:0]       acc_r;
   logic [ACLS_DW-1:0]       stk_r [DEPTH];
   logic                     loaded_r;
   logic                     ptr_r;
   logic                     done_r;
   logic [ACLS_DW-1:0]       val_nxt;
   logic [ACLS_DW-1:0]       octal_val;
   logic [ACLS_DW-1:0]       field_mask;
   logic                     is_load;
   logic                     is_store;
   logic                     is_dw;
   logic                     is_bit;
   logic                     fin_go;

   wire go = clk_en && op_valid && state_r == ACLS_S_IDLE && op != ACLS_OP_NOP;

   assign is_load  = op_r inside {ACLS_OP_WLD, ACLS_OP_DWLD, ACLS_OP_BFLD, ACLS_OP_OALD};
   assign is_store = op_r inside {ACLS_OP_WST, ACLS_OP_DWST, ACLS_OP_BFST};
   assign is_dw    = op_r inside {ACLS_OP_DWLD, ACLS_OP_DWST, ACLS_OP_DWAND};
   assign is_bit   = op_r inside {ACLS_OP_BFLD, ACLS_OP_BFST};
   assign fin_go   = clk_en && state_r == ACLS_S_FIN;

   // Octal digits to binary, three bits per digit
   always_comb
   begin
      octal_val = '0;
      for (int d = 0; d < 4; d++)
      begin
         octal_val[3*d +: 3] = opnd_r[4*d +: 3];
      end
   end

   // Mask of the low cnt_r bits
   always_comb
   begin
      field_mask = '0;
      for (int b = 0; b < ACLS_DW; b++)
      begin
         field_mask[b] = (6'(b) < cnt_r);
      end
   end

   // Final value written to accumulator
   always_comb
   begin
      case (op_r)
         ACLS_OP_WLD:   val_nxt = {16'h0000, opnd_r[15:0]};
         ACLS_OP_DWLD:  val_nxt = opnd_r;
         ACLS_OP_BFLD:  val_nxt = opnd_r & field_mask;
         ACLS_OP_OALD:  val_nxt = octal_val;
         ACLS_OP_POP:   val_nxt = stk_r[0];
         ACLS_OP_WAND:  val_nxt = {16'h0000, acc_r[15:0] & opnd_r[15:0]};
         ACLS_OP_DWAND: val_nxt = acc_r & opnd_r;
         default:       val_nxt = acc_r;
      endcase
   end

   // Sequencer of one operation
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r <= ACLS_S_IDLE;
         op_r    <= ACLS_OP_NOP;
         src_r   <= ACLS_SRC_MEM;
         addr_r  <= '0;
         opnd_r  <= '0;
         cnt_r   <= '0;
         idx_r   <= '0;
         ptr_r   <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state_r)
            ACLS_S_IDLE:
               if (go)
               begin
                  op_r   <= op;
                  src_r  <= op_src;
                  addr_r <= op_addr;
                  opnd_r <= op_imm;
                  cnt_r  <= (op_count == '0) ? 6'h01 :
                            (op_count > ACLS_CNT_MAX) ? ACLS_CNT_MAX : op_count;
                  idx_r  <= '0;
                  ptr_r  <= 1'b0;
                  if (op inside {ACLS_OP_BFLD, ACLS_OP_BFST})
                     state_r <= ACLS_S_BIT;
                  else if (op inside {ACLS_OP_OALD, ACLS_OP_POP})
                     state_r <= ACLS_S_FIN;
                  else if (op_src == ACLS_SRC_IMM && op inside
                           {ACLS_OP_WLD, ACLS_OP_DWLD, ACLS_OP_DWAND})
                     state_r <= ACLS_S_FIN;
                  else if (op_src == ACLS_SRC_PTR)
                     state_r <= ACLS_S_PTR;
                  else
                     state_r <= ACLS_S_WRD0;
               end
            ACLS_S_PTR:
            begin
               addr_r <= wmem_rdata;
               if (wmem_rdata >= ACLS_WMEM_WORDS ||
                   (is_dw && wmem_rdata == ACLS_WMEM_WORDS - 16'h0001))
               begin
                  ptr_r   <= 1'b1;
                  state_r <= ACLS_S_FIN;
               end
               else
                  state_r <= ACLS_S_WRD0;
            end
            ACLS_S_WRD0:
            begin
               opnd_r[15:0] <= wmem_rdata;
               state_r      <= is_dw ? ACLS_S_WRD1 : ACLS_S_FIN;
            end
            ACLS_S_WRD1:
            begin
               opnd_r[31:16] <= wmem_rdata;
               state_r       <= ACLS_S_FIN;
            end
            ACLS_S_BIT:
            begin
               opnd_r[idx_r[4:0]] <= bmem_rdata;
               idx_r <= idx_r + 6'h01;
               if (idx_r + 6'h01 == cnt_r)
                  state_r <= ACLS_S_FIN;
            end
            ACLS_S_FIN:
               state_r <= ACLS_S_IDLE;
            default:
               state_r <= ACLS_S_IDLE;
         endcase
      end
   end

   // Memory strobes; read data valid the cycle after the read
   always_comb
   begin
      wmem_rd    = 1'b0;
      wmem_wr    = 1'b0;
      wmem_addr  = addr_r;
      wmem_wdata = (state_r == ACLS_S_WRD1) ? acc_r[31:16] : acc_r[15:0];
      bmem_rd    = go && op == ACLS_OP_BFLD;
      bmem_wr    = 1'b0;
      bmem_addr  = go ? op_addr[ACLS_BAW-1:0] : addr_r[ACLS_BAW-1:0] + ACLS_BAW'(idx_r) +
                   ACLS_BAW'(op_r == ACLS_OP_BFLD);
      bmem_wdata = acc_r[idx_r[4:0]];
      case (state_r)
         ACLS_S_IDLE:
            if (go && !(op inside {ACLS_OP_BFLD, ACLS_OP_BFST,
                                   ACLS_OP_OALD, ACLS_OP_POP}))
            begin
               wmem_addr = op_addr;
               wmem_rd   = op_src == ACLS_SRC_PTR ||
                           (op_src == ACLS_SRC_MEM && !(op inside
                            {ACLS_OP_WST, ACLS_OP_DWST}));
            end
         ACLS_S_PTR:
            if (!(wmem_rdata >= ACLS_WMEM_WORDS ||
                  (is_dw && wmem_rdata == ACLS_WMEM_WORDS - 16'h0001)))
            begin
               wmem_addr = wmem_rdata;
               wmem_rd   = !is_store;
            end
         ACLS_S_WRD0:
            if (is_dw)
            begin
               wmem_addr = addr_r + 16'h0001;
               wmem_rd   = !is_store;
            end
         ACLS_S_WRD1:
         begin
            wmem_addr = addr_r + 16'h0001;
            wmem_wr   = clk_en && op_r == ACLS_OP_DWST;
         end
         ACLS_S_FIN:
            if (clk_en && is_store && !is_bit && !ptr_r)
            begin
               wmem_wr = 1'b1;
            end
         ACLS_S_BIT:
         begin
            bmem_rd = clk_en && op_r == ACLS_OP_BFLD;
            bmem_wr = clk_en && op_r == ACLS_OP_BFST;
         end
         default:
            wmem_rd = 1'b0;
      endcase
   end

   // Accumulator
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         acc_r <= ACLS_ACC_RST;
      else if (clk_en)
      begin
         if (scan_end)
            acc_r <= ACLS_ACC_RST;
         else if (fin_go && !is_store && !ptr_r)
            acc_r <= val_nxt;
      end
   end

   // Pending push: a load arms it, a store cancels it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         loaded_r <= 1'b0;
      else if (clk_en)
      begin
         if (scan_end)
            loaded_r <= 1'b0;
         else if (fin_go && is_load && !ptr_r)
            loaded_r <= 1'b1;
         else if (fin_go && is_store)
            loaded_r <= 1'b0;
      end
   end

   // Stack: push on second load, pop shifts up
   for (genvar g = 0; g < DEPTH; g++)
   begin : g_stk
      always_ff @(posedge clk)
      begin
         if (sys_rst)
            stk_r[g] <= '0;
         else if (clk_en && fin_go && !ptr_r)
         begin
            if (is_load && loaded_r)
               stk_r[g] <= (g == 0) ? acc_r : stk_r[(g == 0) ? 0 : g-1];
            else if (op_r == ACLS_OP_POP)
               stk_r[g] <= (g == DEPTH-1) ? '0 : stk_r[(g == DEPTH-1) ? g : g+1];
         end
      end
   end

   // Status flags; each held until its own kind of update
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         result_zero_flag         <= 1'b0;
         result_negative_flag     <= 1'b0;
         load_zero_flag           <= 1'b0;
         pointer_range_error_flag <= 1'b0;
      end
      else if (fin_go)
      begin
         if (!ptr_r && op_r inside {ACLS_OP_POP, ACLS_OP_WAND, ACLS_OP_DWAND})
            result_zero_flag <= val_nxt == '0;
         if (!ptr_r && op_r == ACLS_OP_DWAND)
            result_negative_flag <= val_nxt[31];
         if (is_load && !ptr_r)
            load_zero_flag <= val_nxt == '0;
         if (src_r == ACLS_SRC_PTR && (is_load || is_store))
            pointer_range_error_flag <= ptr_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         done_r <= 1'b0;
      else if (clk_en)
         done_r <= fin_go;
   end

   assign acc     = acc_r;
   assign op_done = done_r;

   // Assertions
   AST_ZERO_AND: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && op_r == ACLS_OP_WAND && !ptr_r && !scan_end |=> result_zero_flag == (acc_r == '0))
      else $error("zero flag wrong after AND");
   AST_NEG_DAND: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && op_r == ACLS_OP_DWAND && !ptr_r && !scan_end |=> result_negative_flag == acc_r[31])
      else $error("negative flag wrong");
   AST_WLD_UPPER: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && op_r == ACLS_OP_WLD && !ptr_r && !scan_end |=> acc_r[31:16] == 16'h0000)
      else $error("word load left upper bits");
   AST_SCAN_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && scan_end |=> acc_r == '0)
      else $error("accumulator not cleared at scan end");
   AST_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && is_load && loaded_r && !ptr_r |=> stk_r[0] == $past(acc_r))
      else $error("first load not pushed");
   AST_POP: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && op_r == ACLS_OP_POP && !scan_end |=> acc_r == $past(stk_r[0]))
      else $error("pop value wrong");
   AST_LDZERO: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && is_load && !ptr_r && !scan_end |=> load_zero_flag == (acc_r == '0))
      else $error("load zero flag wrong");
   AST_STORE_CANCEL: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && is_store |=> !loaded_r)
      else $error("store did not cancel push");
   AST_BF_MASK: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && op_r == ACLS_OP_BFLD && !scan_end |=> (acc_r & ~$past(field_mask)) == '0)
      else $error("bit field upper bits not zero");
   AST_DWST_HI: assert property (@(posedge clk) disable iff (sys_rst)
      fin_go && $past(clk_en) && op_r == ACLS_OP_DWST && !ptr_r |->
         $past(wmem_wr) && $past(wmem_addr) == wmem_addr + 16'h0001 &&
         $past(wmem_wdata) == acc_r[31:16])
      else $error("double store high word missing");

   COV_DWLD:  cover property (@(posedge clk) fin_go && op_r == ACLS_OP_DWLD);
   COV_PUSH:  cover property (@(posedge clk) fin_go && is_load && loaded_r);
   COV_POP:   cover property (@(posedge clk) fin_go && op_r == ACLS_OP_POP);
   COV_PTRERR: cover property (@(posedge clk) fin_go && ptr_r);
endmodule

`default_nettype wire

// ===== pkg/acls_pkg.sv
// Package for the accumulator load/store datapath
package acls_pkg;
   localparam int ACLS_DW      = 32;
   localparam int ACLS_WW      = 16;
   localparam int ACLS_AW      = 16;
   localparam int ACLS_BAW     = 10;
   localparam int ACLS_CNTW    = 6;
   localparam int ACLS_DEPTH   = 8;
   localparam logic [ACLS_AW-1:0] ACLS_WMEM_WORDS = 16'h1000;
   localparam logic [ACLS_DW-1:0] ACLS_ACC_RST    = 32'h0000_0000;
   localparam logic [5:0]         ACLS_CNT_MAX    = 6'h20;

   typedef enum logic [3:0]
   {
      ACLS_OP_NOP     = 4'h0,
      ACLS_OP_WLD     = 4'h1,
      ACLS_OP_DWLD    = 4'h2,
      ACLS_OP_BFLD    = 4'h3,
      ACLS_OP_OALD    = 4'h4,
      ACLS_OP_WST     = 4'h5,
      ACLS_OP_DWST    = 4'h6,
      ACLS_OP_BFST    = 4'h7,
      ACLS_OP_POP     = 4'h8,
      ACLS_OP_WAND    = 4'h9,
      ACLS_OP_DWAND   = 4'hA
   } acls_op_e;

   typedef enum logic [1:0]
   {
      ACLS_SRC_MEM  = 2'h0,
      ACLS_SRC_PTR  = 2'h1,
      ACLS_SRC_IMM  = 2'h2
   } acls_src_e;
endpackage

// ===== testbench/acls_mem_model.sv
// Word memory and discrete bit memory seen by the accumulator datapath
`timescale 1ns/1ps
`default_nettype none

module acls_mem_model
(
   // Clock
   input  wire logic        clk,
   // Word memory
   input  wire logic        wmem_rd,
   input  wire logic        wmem_wr,
   input  wire logic [15:0] wmem_addr,
   input  wire logic [15:0] wmem_wdata,
   output var  logic [15:0] wmem_rdata,
   // Discrete bit memory
   input  wire logic        bmem_rd,
   input  wire logic        bmem_wr,
   input  wire logic [9:0]  bmem_addr,
   input  wire logic        bmem_wdata,
   output var  logic        bmem_rdata
);
   logic [15:0] wm [0:4095];
   logic        bm [0:1023];

   initial
   begin
      wmem_rdata = 16'h0000;
      bmem_rdata = 1'b0;
   end

   // Read data valid one cycle after the strobe, then toggles so stale data never matches
   always @(posedge clk)
   begin
      if (wmem_wr)
         wm[wmem_addr[11:0]] <= wmem_wdata;
      if (bmem_wr)
         bm[bmem_addr] <= bmem_wdata;
      wmem_rdata <= wmem_rd ? wm[wmem_addr[11:0]] : ~wmem_rdata;
      bmem_rdata <= bmem_rd ? bm[bmem_addr] : ~bmem_rdata;
   end
endmodule

`default_nettype wire

// ===== testbench/test_accumulator_load_store_logic.sv
// Self-checking bench for the accumulator load/store datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
   $display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module test_accumulator_load_store_logic;
   import acls_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        clk_en = 1'b1;
   acls_op_e    op = ACLS_OP_NOP;
   logic        op_valid = 1'b0;
   acls_src_e   op_src = ACLS_SRC_MEM;
   logic [15:0] op_addr = 16'h0000;
   logic [31:0] op_imm = 32'h0000_0000;
   logic [5:0]  op_count = 6'h01;
   logic        scan_end = 1'b0;
   logic        op_done, wmem_rd, wmem_wr, bmem_rd, bmem_wr, bmem_wdata, bmem_rdata;
   logic [15:0] wmem_addr, wmem_wdata, wmem_rdata;
   logic [9:0]  bmem_addr;
   logic [31:0] acc;
   logic        zf, nf, lzf, pef;
   int          err_total = 0;
   int          comparisons = 0;
   int          cyc = 0;

   acls_core acls_core_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .op(op),
      .op_valid(op_valid), .op_src(op_src), .op_addr(op_addr), .op_imm(op_imm),
      .op_count(op_count), .scan_end(scan_end), .op_done(op_done), .wmem_rd(wmem_rd),
      .wmem_wr(wmem_wr), .wmem_addr(wmem_addr), .wmem_wdata(wmem_wdata),
      .wmem_rdata(wmem_rdata), .bmem_rd(bmem_rd), .bmem_wr(bmem_wr),
      .bmem_addr(bmem_addr), .bmem_wdata(bmem_wdata), .bmem_rdata(bmem_rdata), .acc(acc),
      .result_zero_flag(zf), .result_negative_flag(nf), .load_zero_flag(lzf),
      .pointer_range_error_flag(pef));

   acls_mem_model acls_mem_model_i (.clk(clk), .wmem_rd(wmem_rd), .wmem_wr(wmem_wr),
      .wmem_addr(wmem_addr), .wmem_wdata(wmem_wdata), .wmem_rdata(wmem_rdata),
      .bmem_rd(bmem_rd), .bmem_wr(bmem_wr), .bmem_addr(bmem_addr),
      .bmem_wdata(bmem_wdata), .bmem_rdata(bmem_rdata));

   always #12.5 clk = ~clk;

   task automatic final_report();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         final_report();
      end
   end

   // One operation, all operands together for one cycle, then wait for completion
   task automatic run(acls_op_e o, acls_src_e s, logic [15:0] a, logic [31:0] im,
                      logic [5:0] c);
      int n = 0;
      @(posedge clk);
      op <= o; op_src <= s; op_addr <= a; op_imm <= im; op_count <= c;
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (op_done !== 1'b1 && n < 80);
      if (n >= 80)
      begin
         err_total++;
         $display("unexpected op_done expected 1 seen %b", op_done);
      end
   endtask

   task automatic t_double();
      run(ACLS_OP_DWLD, ACLS_SRC_IMM, 16'h0000, 32'hFEDC_BA98, 6'h01);
      `CHK("acc", 32'hFEDC_BA98, acc)
      run(ACLS_OP_DWAND, ACLS_SRC_IMM, 16'h0000, 32'h8000_00FF, 6'h01);
      `CHK("acc", 32'h8000_0098, acc)
      `CHK("neg", 1'b1, nf)
      `CHK("zero", 1'b0, zf)
      run(ACLS_OP_DWAND, ACLS_SRC_IMM, 16'h0000, 32'h0000_0F00, 6'h01);
      `CHK("zero", 1'b1, zf)
      `CHK("neg", 1'b0, nf)
      acls_mem_model_i.wm[12'h100] = 16'h1234;
      acls_mem_model_i.wm[12'h101] = 16'h5678;
      run(ACLS_OP_DWLD, ACLS_SRC_MEM, 16'h0100, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'h5678_1234, acc)
      `CHK("load_zero", 1'b0, lzf)
      run(ACLS_OP_DWST, ACLS_SRC_MEM, 16'h0180, 32'h0000_0000, 6'h01);
      `CHK("wm180", 16'h1234, acls_mem_model_i.wm[12'h180])
      `CHK("wm181", 16'h5678, acls_mem_model_i.wm[12'h181])
   endtask

   task automatic t_word();
      acls_mem_model_i.wm[12'h200] = 16'hA5A5;
      acls_mem_model_i.wm[12'h201] = 16'h0F0F;
      acls_mem_model_i.wm[12'h202] = 16'h5050;
      run(ACLS_OP_DWLD, ACLS_SRC_IMM, 16'h0000, 32'hFFFF_FFFF, 6'h01);
      run(ACLS_OP_WLD, ACLS_SRC_MEM, 16'h0200, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'h0000_A5A5, acc)
      run(ACLS_OP_WAND, ACLS_SRC_MEM, 16'h0201, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'h0000_0505, acc)
      `CHK("zero", 1'b0, zf)
      run(ACLS_OP_WST, ACLS_SRC_MEM, 16'h0210, 32'h0000_0000, 6'h01);
      `CHK("wm210", 16'h0505, acls_mem_model_i.wm[12'h210])
      run(ACLS_OP_WAND, ACLS_SRC_MEM, 16'h0202, 32'h0000_0000, 6'h01);
      `CHK("zero", 1'b1, zf)
      run(ACLS_OP_POP, ACLS_SRC_MEM, 16'h0000, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'hFFFF_FFFF, acc)
   endtask

   task automatic t_bits();
      logic [6:0] got;
      for (int i = 0; i < 8; i++)
         acls_mem_model_i.bm[10'h008 + i] = (8'hD9 >> i) & 1;
      for (int i = 0; i < 32; i++)
         acls_mem_model_i.bm[10'h080 + i] = 1'b0;
      acls_mem_model_i.bm[10'h045] = 1'b1;
      acls_mem_model_i.bm[10'h046] = 1'b0;
      run(ACLS_OP_BFLD, ACLS_SRC_MEM, 16'h0008, 32'h0000_0000, 6'h07);
      `CHK("acc", 32'h0000_0059, acc)
      run(ACLS_OP_BFST, ACLS_SRC_MEM, 16'h0040, 32'h0000_0000, 6'h05);
      for (int i = 0; i < 7; i++)
         got[i] = acls_mem_model_i.bm[10'h040 + i];
      `CHK("bits40", 7'h39, got)
      run(ACLS_OP_BFLD, ACLS_SRC_MEM, 16'h0080, 32'h0000_0000, 6'h20);
      `CHK("acc", 32'h0000_0000, acc)
      `CHK("load_zero", 1'b1, lzf)
      run(ACLS_OP_OALD, ACLS_SRC_IMM, 16'h0000, 32'h0000_1777, 6'h01);
      `CHK("acc", 32'h0000_03FF, acc)
      `CHK("load_zero", 1'b0, lzf)
   endtask

   task automatic t_ptr();
      acls_mem_model_i.wm[12'h300] = 16'h2000;
      acls_mem_model_i.wm[12'h301] = 16'h0400;
      acls_mem_model_i.wm[12'h400] = 16'hBEEF;
      run(ACLS_OP_WLD, ACLS_SRC_PTR, 16'h0300, 32'h0000_0000, 6'h01);
      `CHK("ptr_err", 1'b1, pef)
      run(ACLS_OP_WLD, ACLS_SRC_PTR, 16'h0301, 32'h0000_0000, 6'h01);
      `CHK("ptr_err", 1'b0, pef)
      `CHK("acc", 32'h0000_BEEF, acc)
   endtask

   task automatic t_stack();
      @(posedge clk);
      scan_end <= 1'b1;
      @(posedge clk);
      scan_end <= 1'b0;
      #1;
      `CHK("acc", 32'h0000_0000, acc)
      for (int i = 1; i <= 10; i++)
         run(ACLS_OP_DWLD, ACLS_SRC_IMM, 16'h0000, 32'(i), 6'h01);
      for (int i = 9; i >= 2; i--)
      begin
         run(ACLS_OP_POP, ACLS_SRC_MEM, 16'h0000, 32'h0000_0000, 6'h01);
         `CHK("acc", 32'(i), acc)
      end
      run(ACLS_OP_POP, ACLS_SRC_MEM, 16'h0000, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'h0000_0000, acc)
      `CHK("zero", 1'b1, zf)
      run(ACLS_OP_DWLD, ACLS_SRC_IMM, 16'h0000, 32'h0000_0077, 6'h01);
      run(ACLS_OP_WST, ACLS_SRC_MEM, 16'h0220, 32'h0000_0000, 6'h01);
      run(ACLS_OP_DWLD, ACLS_SRC_IMM, 16'h0000, 32'h0000_0088, 6'h01);
      run(ACLS_OP_POP, ACLS_SRC_MEM, 16'h0000, 32'h0000_0000, 6'h01);
      `CHK("acc", 32'h0000_0000, acc)
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_double();
      t_word();
      t_bits();
      t_ptr();
      t_stack();
      final_report();
   end
endmodule

`default_nettype wire
